// *** verilog/hwd_host_window.sv ***
// Host window decode with wait control and clock strap capture
`timescale 1ns/1ps
`include "hwd_params.svh"
module hwd_host_window
  import hwd_pkg::*;
#(
  parameter int ADDR_W  = `HWD_ADDR_W,
  parameter int DATA_W  = `HWD_DATA_W,
  parameter bit FB_IS_4M = 1'b0
)
(
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic              host_select_n,
  input  wire logic              host_write_n,
  input  wire logic              host_read_n,
  input  wire logic [ADDR_W-1:1] host_addr,
  input  wire logic [DATA_W-1:0] host_data_in,
  output logic      [DATA_W-1:0] host_data_out,
  output logic                   host_data_oe_n,
  output logic                   host_wait_n,
  input  wire logic              clock_source_strap,
  input  wire logic              osc_frequency_strap,
  output logic                   use_osc,
  output logic                   osc_is_13mhz,
  output logic                   tgt_req,
  output logic                   tgt_we,
  output logic                   tgt_is_fb,
  output logic      [ADDR_W-2:0] tgt_off,
  output logic      [DATA_W-1:0] tgt_wdata,
  output logic                   tgt_fb_hole,
  input  wire logic [DATA_W-1:0] tgt_rdata,
  input  wire logic              tgt_ack
);
  hwd_tgt_if  tif ();
  hwd_state_e state_r;
  hwd_state_e state_nxt;

  logic cs_s1_r, cs_s2_r, wr_s1_r, wr_s2_r, rd_s1_r, rd_s2_r;
  logic [ADDR_W-1:1] a_s1_r, a_s2_r;
  logic [DATA_W-1:0] d_s1_r, d_s2_r;
  logic              strobe;
  logic [ADDR_W-1:0] byte_addr;
  logic              is_fb;
  logic [ADDR_W-1:0] fb_size;
  logic              req_r;
  logic              we_r;
  hwd_tgt_e          tgt_r;
  logic [ADDR_W-2:0] off_r;
  logic [DATA_W-1:0] wdata_r;
  logic              hole_r;
  logic              read_r;

  hwd_straps u_straps (
    .clock               (clock),
    .srst                (srst),
    .clock_source_strap  (clock_source_strap),
    .osc_frequency_strap (osc_frequency_strap),
    .use_osc             (use_osc),
    .osc_is_13mhz        (osc_is_13mhz)
  );

  // Host pins are asynchronous to clock; double-flop them
  always_ff @(posedge clock)
  begin
    cs_s1_r <= host_select_n;
    cs_s2_r <= cs_s1_r;
    wr_s1_r <= host_write_n;
    wr_s2_r <= wr_s1_r;
    rd_s1_r <= host_read_n;
    rd_s2_r <= rd_s1_r;
    a_s1_r  <= host_addr;
    a_s2_r  <= a_s1_r;
    d_s1_r  <= host_data_in;
    d_s2_r  <= d_s1_r;
  end

  // Whole 24-bit window under one select
  assign strobe    = !cs_s2_r && (!wr_s2_r || !rd_s2_r);
  assign byte_addr = {a_s2_r, 1'b0};
  assign is_fb     = byte_addr[`HWD_SEL_BIT];
  assign fb_size   = FB_IS_4M ? `HWD_FB_SIZE_4M : `HWD_FB_SIZE_2M;

  // One access per strobe; a new one needs the strobe released
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      HWD_IDLE: if (strobe) state_nxt = HWD_WAIT;
      HWD_WAIT: if (tif.ack) state_nxt = HWD_DONE;
      HWD_DONE: if (!strobe) state_nxt = HWD_IDLE;
      // Code 2'b10 is unused; fall back to idle rather than lock up
      default:  state_nxt = HWD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state_r <= HWD_IDLE;
    else
      state_r <= state_nxt;
  end

  // Latch the request as the access starts
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      tgt_r   <= HWD_TGT_REG;
      off_r   <= '0;
      wdata_r <= '0;
      hole_r  <= 1'b0;
      read_r  <= 1'b0;
    end
    else if (state_r == HWD_IDLE && strobe)
    begin
      req_r   <= 1'b1;
      we_r    <= !wr_s2_r;
      read_r  <= wr_s2_r;
      tgt_r   <= is_fb ? HWD_TGT_FB : HWD_TGT_REG;
      // Offset relative to the base of the selected half (bit 23 dropped)
      off_r   <= is_fb ? byte_addr[ADDR_W-2:0]
                       : byte_addr[ADDR_W-2:0];
      hole_r  <= is_fb &&
                 (byte_addr - `HWD_FB_BASE) >= fb_size;
      wdata_r <= d_s2_r;
    end
    else if (tif.ack)
      req_r <= 1'b0;
  end

  // Capture read data for the host
  always_ff @(posedge clock)
  begin
    if (srst)
      host_data_out <= '0;
    else if (state_r == HWD_WAIT && tif.ack && read_r)
      host_data_out <= tif.rdata;
  end

  // Drive data bus while the read is held; enable is active low
  assign host_data_oe_n = !(state_r == HWD_DONE && read_r && strobe);
  // Wait low from strobe until target answers
  assign host_wait_n = !((state_r == HWD_IDLE && strobe) ||
                         state_r == HWD_WAIT);

  assign tif.req     = req_r;
  assign tif.we      = we_r;
  assign tif.tgt     = tgt_r;
  assign tif.off     = off_r;
  assign tif.wdata   = wdata_r;
  assign tif.fb_hole = hole_r;
  assign tif.rdata   = tgt_rdata;
  assign tif.ack     = tgt_ack & req_r;
  assign tgt_req     = tif.req;
  assign tgt_we      = tif.we;
  assign tgt_is_fb   = (tif.tgt == HWD_TGT_FB);
  assign tgt_off     = tif.off;
  assign tgt_wdata   = tif.wdata;
  assign tgt_fb_hole = tif.fb_hole;

  sequence s_start;
    state_r == HWD_IDLE && strobe;
  endsequence
  sequence s_served;
    state_r == HWD_WAIT && tif.ack;
  endsequence

  AST_WAIT_LOW: assert property (@(posedge clock) disable iff (srst)
    state_r == HWD_WAIT |-> !host_wait_n)
    else $error("Wait released before target answer");
  AST_WAIT_FREE: assert property (@(posedge clock) disable iff (srst)
    s_served ##1 1 |-> host_wait_n)
    else $error("Wait held after target answer");
  AST_REG_ROUTE: assert property (@(posedge clock) disable iff (srst)
    s_start and !is_fb |=> !tgt_is_fb && tgt_req)
    else $error("Low half not routed to registers");
  AST_FB_ROUTE: assert property (@(posedge clock) disable iff (srst)
    s_start and is_fb |=> tgt_is_fb && tgt_req)
    else $error("High half not routed to frame buffer");
  AST_SINGLE: assert property (@(posedge clock) disable iff (srst)
    s_served |=> !tgt_req until !strobe)
    else $error("Second access in one strobe");
  AST_HOLE: assert property (@(posedge clock) disable iff (srst)
    tgt_req && tgt_fb_hole |-> tgt_is_fb)
    else $error("Hole flagged outside frame buffer");
  // Hole flag must match the fitted memory size, not just the half
  AST_HOLE_SIZE: assert property (@(posedge clock) disable iff (srst)
    tgt_req && tgt_is_fb |-> tgt_fb_hole == (tgt_off >= fb_size))
    else $error("Hole flag disagrees with fitted size");
  AST_IDLE_NOCS: assert property (@(posedge clock) disable iff (srst)
    cs_s2_r && state_r == HWD_IDLE |=> state_r == HWD_IDLE)
    else $error("Access started without select");
endmodule : hwd_host_window

// *** verilog/hwd_params.svh ***
// Constants for the host window decode and clock strap block
`ifndef HWD_PARAMS_SVH
`define HWD_PARAMS_SVH
`define HWD_ADDR_W        24
`define HWD_DATA_W        16
`define HWD_SEL_BIT       23
`define HWD_FB_BASE       24'h80_0000
`define HWD_FB_SIZE_2M    24'h20_0000
`define HWD_FB_SIZE_4M    24'h40_0000
`define HWD_OSC_SLOW_HZ   32768
`define HWD_OSC_FAST_HZ   13000000
`define HWD_CLK_HZ        10000000
`endif

// *** verilog/hwd_pkg.sv ***
// Types shared by the host window decode block
package hwd_pkg;
  typedef enum logic [1:0] {
    HWD_IDLE = 2'b00,
    HWD_WAIT = 2'b01,
    HWD_DONE = 2'b11
  } hwd_state_e;
  typedef enum logic {
    HWD_TGT_REG = 1'b0,
    HWD_TGT_FB  = 1'b1
  } hwd_tgt_e;
endpackage : hwd_pkg

// *** verilog/hwd_tgt_if.sv ***
// Carrier between decoder and engine-side target port
`timescale 1ns/1ps
interface hwd_tgt_if;
  import hwd_pkg::*;
  logic        req;
  logic        we;
  hwd_tgt_e    tgt;
  logic [22:0] off;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        fb_hole;
  modport dec (output req, we, tgt, off, wdata, fb_hole,
               input rdata, ack);
  modport tgt_side (input req, we, tgt, off, wdata, fb_hole,
                    output rdata, ack);
endinterface : hwd_tgt_if

// *** verilog/hwd_straps.sv ***
// Clock strap capture and clock source selection
`timescale 1ns/1ps
`include "hwd_params.svh"
module hwd_straps
  import hwd_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clock_source_strap,
  input  wire logic osc_frequency_strap,
  output logic      use_osc,
  output logic      osc_is_13mhz
);
  logic src_s1_r;
  logic src_s2_r;
  logic frq_s1_r;
  logic frq_s2_r;

  // Strap pins are asynchronous; two flops before use
  always_ff @(posedge clock)
  begin
    src_s1_r <= clock_source_strap;
    src_s2_r <= src_s1_r;
    frq_s1_r <= osc_frequency_strap;
    frq_s2_r <= frq_s1_r;
  end

  // Track only during reset, freeze at release
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      use_osc      <= src_s2_r;  // 0 PLL, 1 oscillator
      osc_is_13mhz <= frq_s2_r;  // 0 32.768 kHz, 1 13 MHz
    end
  end

  AST_STRAP_HOLD: assert property (@(posedge clock)
    !srst && !$past(srst) |-> $stable(use_osc) && $stable(osc_is_13mhz))
    else $error("Strap value changed outside reset");
  AST_STRAP_SRC: assert property (@(posedge clock)
    $past(srst) |-> use_osc == $past(src_s2_r))
    else $error("Clock source strap not captured");
  AST_STRAP_FRQ: assert property (@(posedge clock)
    $past(srst) |-> osc_is_13mhz == $past(frq_s2_r))
    else $error("Frequency strap not captured");
endmodule : hwd_straps

// *** tb/hwd_tgt_model.sv ***
// Engine-side responder that answers target requests
`timescale 1ns/1ps
module hwd_tgt_model (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        tgt_req,
  input  wire logic [22:0] tgt_off,
  input  wire logic [3:0]  slow,
  output logic      [15:0] tgt_rdata,
  output logic             tgt_ack
);
  logic [3:0] cnt_r;
  // One ack per request after a chosen stall
  always_ff @(posedge clock)
  begin
    cnt_r   <= (srst || !tgt_req || tgt_ack) ? 4'h0 : cnt_r + 4'h1;
    tgt_ack <= !srst && tgt_req && !tgt_ack && cnt_r >= slow;
  end
  // Data is junk outside the ack cycle, so stale reads show up
  assign tgt_rdata = tgt_ack ? tgt_off[15:0] ^ 16'h5a5a : {4{cnt_r}};
endmodule : hwd_tgt_model

// *** tb/tb_top.sv ***
// Self-checking bench for the host window decode block
`timescale 1ns/1ps
module tb_top;
  logic        clock, srst, host_select_n, host_write_n, host_read_n;
  logic [23:1] host_addr;
  logic [15:0] host_data_in, host_data_out, tgt_wdata, tgt_rdata;
  logic        host_data_oe_n, host_wait_n, use_osc, osc_is_13mhz;
  logic        clock_source_strap, osc_frequency_strap, tgt_ack;
  logic        tgt_req, tgt_we, tgt_is_fb, tgt_fb_hole, req_q;
  logic [22:0] tgt_off;
  logic [3:0]  slow;
  logic [31:0] seed;
  logic [41:0] e;
  logic [41:0] exp_q[$];
  logic [23:1] addrs[6] = '{23'h0, 23'h3f_ffff, 23'h40_0000,
                            23'h4f_ffff, 23'h50_0000, 23'h7f_ffff};
  int          errors, n_checks, cycles, i;
  hwd_host_window u_hwd_host_window (
    .clock               (clock),
    .srst                (srst),
    .host_select_n       (host_select_n),
    .host_write_n        (host_write_n),
    .host_read_n         (host_read_n),
    .host_addr           (host_addr),
    .host_data_in        (host_data_in),
    .host_data_out       (host_data_out),
    .host_data_oe_n      (host_data_oe_n),
    .host_wait_n         (host_wait_n),
    .clock_source_strap  (clock_source_strap),
    .osc_frequency_strap (osc_frequency_strap),
    .use_osc             (use_osc),
    .osc_is_13mhz        (osc_is_13mhz),
    .tgt_req             (tgt_req),
    .tgt_we              (tgt_we),
    .tgt_is_fb           (tgt_is_fb),
    .tgt_off             (tgt_off),
    .tgt_wdata           (tgt_wdata),
    .tgt_fb_hole         (tgt_fb_hole),
    .tgt_rdata           (tgt_rdata),
    .tgt_ack             (tgt_ack)
  );
  hwd_tgt_model u_hwd_tgt_model (.clock(clock), .srst(srst),
    .tgt_req(tgt_req), .tgt_off(tgt_off), .slow(slow),
    .tgt_rdata(tgt_rdata), .tgt_ack(tgt_ack));
  // Free-running clock, 100 ns period
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (!ok)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // One host cycle; hold keeps the strobe and moves the address
  task automatic access(input logic we, input logic [23:1] a,
                        input logic [15:0] d, input logic hold);
    int n;
    exp_q.push_back({we, a[23], a[23] && a[22:21] != 2'b00, a[22:1],
                     1'b0, d});
    @(negedge clock);
    host_addr = a;
    host_data_in = d;
    host_select_n = 1'b0; // Sole device on this select
    host_write_n = !we;
    host_read_n = we;
    for (n = 0; n < 10 && host_wait_n !== 1'b0; n++) @(negedge clock);
    for (n = 0; n < 40 && host_wait_n === 1'b0; n++) @(negedge clock);
    chk(n == slow + 3, "wait length");
    if (!we)
      chk(host_data_out === ({a[15:1], 1'b0} ^ 16'h5a5a)
          && host_data_oe_n === 1'b0, "read data");
    if (hold)
    begin
      host_addr = ~a;
      repeat (8) @(negedge clock);
      chk(host_wait_n === 1'b1, "burst extended");
    end
    host_select_n = 1'b1;
    host_write_n = 1'b1;
    host_read_n = 1'b1;
    host_addr = ~a;
    host_data_in = ~d; // Released bus shows junk
    repeat (4) @(negedge clock);
    chk(host_data_oe_n === 1'b1, "bus left driven");
  endtask : access
  // Watchdog; a hang counts as a mismatch and ends the run
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      errors++;
      complete_run();
    end
  end
  // Compare each new target request with the oldest note
  always @(posedge clock)
  begin
    req_q <= tgt_req;
    if (tgt_req && !req_q && !srst)
    begin
      chk(exp_q.size() > 0, "request without access");
      e = exp_q.size() > 0 ? exp_q.pop_front() : '0;
      chk(e[41:16] === {tgt_we, tgt_is_fb, tgt_fb_hole, tgt_off},
          "decode");
      if (e[41])
        chk(e[15:0] === tgt_wdata, "write data");
    end
  end
  // Strap modes, decode corners, then random traffic
  initial
  begin
    {host_select_n, host_write_n, host_read_n} = 3'b111;
    {host_addr, host_data_in, slow} = '0;
    srst = 1'b1; // Held from time zero so no state starts unknown
    {clock_source_strap, osc_frequency_strap} = 2'b00;
    seed = 32'hb7be;
    for (i = 0; i < 4; i++)
    begin
      @(negedge clock);
      srst = 1'b1;
      {clock_source_strap, osc_frequency_strap} = i[1:0];
      repeat (4) @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      {clock_source_strap, osc_frequency_strap} = ~i[1:0];
      repeat (3) @(negedge clock);
      chk({use_osc, osc_is_13mhz} === i[1:0], "strap");
    end
    $display("strap test done");
    foreach (addrs[i])
    begin
      seed = xs(seed);
      access(i[0], addrs[i], seed[15:0], 1'b0);
    end
    $display("decode test done");
    for (i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      slow = seed[27:24];
      access(seed[31], seed[22:0], seed[15:0], i == 3);
    end
    $display("random test done");
    chk(exp_q.size() == 0, "access never reached target");
    complete_run();
  end
endmodule : tb_top
